/* cpsfr_defines.vh */
// Constants shared by the processor status register block and its flag unit.
// Assumes inclusion by bare name from files in the same folder.
`ifndef CPSFR_DEFINES_VH
`define CPSFR_DEFINES_VH

// Register offsets on the software port.
`define CPSFR_ADDR_STATUS    8'h03
`define CPSFR_ADDR_IRQ_STAT  8'h10
`define CPSFR_ADDR_IRQ_MASK  8'h11

// Field positions inside the status byte.
`define CPSFR_BIT_PIN_WAKE   7
`define CPSFR_BIT_CMP_WAKE   6
`define CPSFR_BIT_PAGE       5
`define CPSFR_BIT_TIMEOUT_N  4
`define CPSFR_BIT_PDOWN_N    3
`define CPSFR_BIT_ZERO       2
`define CPSFR_BIT_DCARRY     1
`define CPSFR_BIT_CARRY      0

// Power-on value: top three cleared, time-out and power-down set.
`define CPSFR_STATUS_POR     8'h18
// Bits that any write may change; time-out and power-down stay out.
`define CPSFR_STATUS_WMASK   8'he7
// Zero, digit carry and carry: the bits a flag-setting operation may not write.
`define CPSFR_STATUS_FLAGS   8'h07
`define CPSFR_IRQ_POR        3'h0

// Interrupt event bits.
`define CPSFR_IRQ_TIMEOUT    0
`define CPSFR_IRQ_SLEEP      1
`define CPSFR_IRQ_WAKE       2

// Core operation codes.
`define CPSFR_OP_NONE        4'h0
`define CPSFR_OP_MOVE        4'h1
`define CPSFR_OP_BITCLR      4'h2
`define CPSFR_OP_BITSET      4'h3
`define CPSFR_OP_CLEAR_FILE_INSTR        4'h4
`define CPSFR_OP_ADD         4'h5
`define CPSFR_OP_SUB         4'h6
`define CPSFR_OP_RRF         4'h7
`define CPSFR_OP_RLF         4'h8
`define CPSFR_OP_LOGIC       4'h9
`define CPSFR_OP_WDTCLR      4'ha
`define CPSFR_OP_SLEEP       4'hb

// Program page layout: one page select bit above a 9-bit page offset.
`define CPSFR_PAGE_OFS_W     9

`endif

/* cpsfr_flag_unit.v */
// Result and flag calculation for one core operation.
// Purely combinational; the status register block registers what it needs.
`timescale 1ns/1ps
`default_nettype none
`include "cpsfr_defines.vh"

module cpsfr_flag_unit #(
  parameter W = 8
) (
  input  wire [3:0]   op,
  input  wire [W-1:0] operand_w,
  input  wire [W-1:0] operand_f,
  input  wire [2:0]   bit_sel,
  input  wire         carry_in,
  output reg  [W-1:0] result,
  output reg          zero,
  output reg          digit_carry_flag,
  output reg          carry,
  output reg          zero_upd,
  output reg          digit_carry_upd,
  output reg          carry_upd
);

  ////////////////////////////////////////////////////////////////////////////
  wire [W-1:0] bit_mask;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_mask
      assign bit_mask[g] = (bit_sel == g);
    end
  endgenerate

  wire [W:0] sum  = {1'b0, operand_f} + {1'b0, operand_w};
  wire [4:0] nsum = {1'b0, operand_f[3:0]} + {1'b0, operand_w[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    result          = operand_f;
    zero            = 1'b0;
    digit_carry_flag = 1'b0;
    carry           = 1'b0;
    zero_upd        = 1'b0;
    digit_carry_upd = 1'b0;
    carry_upd       = 1'b0;
    case (op)
      `CPSFR_OP_MOVE:   result = operand_w;
      `CPSFR_OP_BITCLR: result = operand_f & ~bit_mask;
      `CPSFR_OP_BITSET: result = operand_f | bit_mask;
      `CPSFR_OP_CLEAR_FILE_INSTR: begin
        result   = {W{1'b0}};
        zero_upd = 1'b1;
      end
      `CPSFR_OP_ADD: begin
        result           = sum[W-1:0];
        carry            = sum[W];
        digit_carry_flag = nsum[4];
        zero_upd         = 1'b1;
        digit_carry_upd  = 1'b1;
        carry_upd        = 1'b1;
      end
      `CPSFR_OP_SUB: begin
        // File minus W; the flags read as "no borrow".
        result           = operand_f - operand_w;
        carry            = (operand_f >= operand_w);
        digit_carry_flag = (operand_f[3:0] >= operand_w[3:0]);
        zero_upd         = 1'b1;
        digit_carry_upd  = 1'b1;
        carry_upd        = 1'b1;
      end
      `CPSFR_OP_RRF: begin
        result    = {carry_in, operand_f[W-1:1]};
        carry     = operand_f[0];
        carry_upd = 1'b1;
      end
      `CPSFR_OP_RLF: begin
        result    = {operand_f[W-2:0], carry_in};
        carry     = operand_f[W-1];
        carry_upd = 1'b1;
      end
      `CPSFR_OP_LOGIC: begin
        // The core hands in its logic or increment result on operand_w.
        result   = operand_w;
        zero_upd = 1'b1;
      end
      default: result = operand_f;
    endcase
    if (zero_upd) begin
      zero = (result == {W{1'b0}});
    end
  end

endmodule
`default_nettype wire

/* cpsfr_status_reg.v */
// Processor status register: arithmetic flags, reset-cause flags, time-out
// and power-down flags and the program page select bit.
// Assumes one clock, synchronous inputs, and a core that presents at most one
// operation per cycle with its operands already fetched.
//
// How it works
// - Any core operation except watchdog clear and sleep may name the status register as its destination.
// - Flag-updating operations aimed here write only the flags they update, not result bits 2:0.
// - Writes never change the time-out and power-down flags.
// - Clear-file here zeroes top three bits, sets zero, keeps the rest.
// - Pin wake flag set by a pin wake reset, cleared otherwise.
// - Comparator wake flag set by comparator wake reset, cleared otherwise.
// - Page select bit picks program page 0 or 1, 512 locations each.
// - Time-out flag set by power-up, watchdog clear, sleep; cleared on time-out.
// - Power-down flag set by power-up, watchdog clear; cleared by sleep.
// - Zero flag is one when the result is zero.
// - Digit carry reports nibble carry on add, no-borrow on subtract.
// - Carry reports carry, no-borrow, or the bit shifted out by rotates.
`timescale 1ns/1ps
`default_nettype none
`include "cpsfr_defines.vh"

module cpsfr_status_reg #(
  parameter AW = 8
) (
  input  wire                         sys_clk,
  input  wire                         sys_rst,
  // Software register port.
  input  wire [AW-1:0]                reg_addr,
  input  wire [7:0]                   reg_wdata,
  input  wire                         reg_wr,
  input  wire                         reg_rd,
  output reg  [7:0]                   reg_rdata,
  // Core operation port.
  input  wire                         core_valid,
  input  wire [3:0]                   core_op,
  input  wire                         core_dest_status,
  input  wire [7:0]                   core_operand_w,
  input  wire [7:0]                   core_operand_f,
  input  wire [2:0]                   core_bit_sel,
  output reg  [7:0]                   core_result,
  // Reset causes and watchdog event.
  input  wire                         dev_reset,
  input  wire                         wake_pin_cause,
  input  wire                         wake_cmp_cause,
  input  wire                         watchdog_timer_expired,
  // Program page.
  input  wire [`CPSFR_PAGE_OFS_W-1:0] jump_offset,
  output reg  [`CPSFR_PAGE_OFS_W:0]   jump_target,
  // Status view.
  output reg  [7:0]                   processor_status,
  output wire                         program_page_select,
  output wire                         watchdog_timeout_flag_n,
  output wire                         powerdown_flag_n,
  output wire                         irq
);

  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] fu_result;
  wire       fu_zero;
  wire       fu_dc;
  wire       fu_carry;
  wire       fu_zero_upd;
  wire       fu_dc_upd;
  wire       fu_carry_upd;

  cpsfr_flag_unit #(
    .W (8)
  ) u_flags (
    .op               (core_valid ? core_op : `CPSFR_OP_NONE),
    .operand_w        (core_operand_w),
    .operand_f        (core_dest_status ? processor_status : core_operand_f),
    .bit_sel          (core_bit_sel),
    .carry_in         (processor_status[`CPSFR_BIT_CARRY]),
    .result           (fu_result),
    .zero             (fu_zero),
    .digit_carry_flag (fu_dc),
    .carry            (fu_carry),
    .zero_upd         (fu_zero_upd),
    .digit_carry_upd  (fu_dc_upd),
    .carry_upd        (fu_carry_upd)
  );

  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0] next_status;
  reg  [2:0] irq_stat;
  reg  [2:0] irq_mask;
  reg  [2:0] next_irq_stat;

  wire is_wdtclr  = core_valid && (core_op == `CPSFR_OP_WDTCLR);
  wire is_sleep   = core_valid && (core_op == `CPSFR_OP_SLEEP);
  wire core_wr_st = core_valid && core_dest_status &&
                    (core_op != `CPSFR_OP_NONE) &&
                    (core_op != `CPSFR_OP_WDTCLR) &&
                    (core_op != `CPSFR_OP_SLEEP);
  wire sw_wr_st   = reg_wr && (reg_addr == `CPSFR_ADDR_STATUS);
  wire [7:0] wmask = `CPSFR_STATUS_WMASK;
  wire       flag_op = fu_zero_upd || fu_dc_upd || fu_carry_upd;
  // A flag-setting operation writes only the flags it updates, so a clear-file keeps digit carry and carry.
  wire [7:0] core_wmask = flag_op ? (wmask & ~`CPSFR_STATUS_FLAGS) : wmask;

  assign program_page_select     = processor_status[`CPSFR_BIT_PAGE];
  assign watchdog_timeout_flag_n = processor_status[`CPSFR_BIT_TIMEOUT_N];
  assign powerdown_flag_n        = processor_status[`CPSFR_BIT_PDOWN_N];
  assign irq                     = |(irq_stat & irq_mask);

  always @* begin
    next_status = processor_status;
    // The core owns the cycle when both it and software write this register.
    if (core_wr_st) begin
      next_status = (fu_result & core_wmask) | (processor_status & ~core_wmask);
    end else if (sw_wr_st) begin
      next_status = (reg_wdata & wmask) | (processor_status & ~wmask);
    end
    if (fu_zero_upd) begin
      next_status[`CPSFR_BIT_ZERO] = fu_zero;
    end
    if (fu_dc_upd) begin
      next_status[`CPSFR_BIT_DCARRY] = fu_dc;
    end
    if (fu_carry_upd) begin
      next_status[`CPSFR_BIT_CARRY] = fu_carry;
    end
    if (is_wdtclr) begin
      next_status[`CPSFR_BIT_TIMEOUT_N] = 1'b1;
      next_status[`CPSFR_BIT_PDOWN_N]   = 1'b1;
    end
    if (is_sleep) begin
      next_status[`CPSFR_BIT_TIMEOUT_N] = 1'b1;
      next_status[`CPSFR_BIT_PDOWN_N]   = 1'b0;
    end
    // A time-out in the same cycle as a clear must not be lost.
    if (watchdog_timer_expired) begin
      next_status[`CPSFR_BIT_TIMEOUT_N] = 1'b0;
    end
  end

  always @* begin
    next_irq_stat = irq_stat;
    if (reg_rd && (reg_addr == `CPSFR_ADDR_IRQ_STAT)) begin
      next_irq_stat = 3'h0;
    end
    // Set wins over the read-clear in the same cycle.
    if (watchdog_timer_expired) begin
      next_irq_stat[`CPSFR_IRQ_TIMEOUT] = 1'b1;
    end
    if (is_sleep) begin
      next_irq_stat[`CPSFR_IRQ_SLEEP] = 1'b1;
    end
    if (dev_reset && (wake_pin_cause || wake_cmp_cause)) begin
      next_irq_stat[`CPSFR_IRQ_WAKE] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // Arithmetic flags have no defined power-on value; zero is chosen.
      processor_status <= `CPSFR_STATUS_POR;
    end else if (dev_reset) begin
      processor_status[`CPSFR_BIT_PIN_WAKE] <= wake_pin_cause;
      processor_status[`CPSFR_BIT_CMP_WAKE] <= wake_cmp_cause;
      processor_status[`CPSFR_BIT_PAGE]     <= 1'b0;
      if (watchdog_timer_expired) begin
        processor_status[`CPSFR_BIT_TIMEOUT_N] <= 1'b0;
      end
    end else begin
      processor_status <= next_status;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_stat <= `CPSFR_IRQ_POR;
      irq_mask <= `CPSFR_IRQ_POR;
    end else begin
      irq_stat <= next_irq_stat;
      if (reg_wr && (reg_addr == `CPSFR_ADDR_IRQ_MASK)) begin
        irq_mask <= reg_wdata[2:0];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata   <= 8'h00;
      core_result <= 8'h00;
      jump_target <= {(`CPSFR_PAGE_OFS_W + 1){1'b0}};
    end else begin
      core_result <= fu_result;
      // Page select forms the top program address bit.
      jump_target <= {processor_status[`CPSFR_BIT_PAGE], jump_offset};
      reg_rdata   <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `CPSFR_ADDR_STATUS:   reg_rdata <= processor_status;
          `CPSFR_ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat};
          `CPSFR_ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* cpsfr_properties.sv */
// Concurrent checks on the ports of the processor status register block.
// Assumes it is bound to cpsfr_status_reg: one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "cpsfr_defines.vh"
module cpsfr_properties #(
  parameter AW = 8
) (
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_rdata,
  input wire logic          core_valid,
  input wire logic [3:0]    core_op,
  input wire logic          core_dest_status,
  input wire logic [7:0]    core_result,
  input wire logic          dev_reset,
  input wire logic          wake_pin_cause,
  input wire logic          wake_cmp_cause,
  input wire logic          watchdog_timer_expired,
  input wire logic [8:0]    jump_offset,
  input wire logic [9:0]    jump_target,
  input wire logic [7:0]    processor_status,
  input wire logic          watchdog_timeout_flag_n,
  input wire logic          powerdown_flag_n
);
  // Cycles with no competing writer, so a software access alone decides the result.
  wire quiet = !core_valid && !dev_reset && !watchdog_timer_expired;
  wire st = reg_addr == `CPSFR_ADDR_STATUS;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  property p_por; $fell(sys_rst) |-> processor_status == `CPSFR_STATUS_POR; endproperty
  a_por: assert property (p_por) else $error("status not at power-on value");
  property p_ro; reg_wr && st && quiet |=> processor_status[4:3] == $past(processor_status[4:3]); endproperty
  a_ro: assert property (p_ro) else $error("write changed time-out or power-down");
  property p_wdt; watchdog_timer_expired |=> !watchdog_timeout_flag_n; endproperty
  a_wdt: assert property (p_wdt) else $error("time-out flag not cleared");
  property p_sleep; core_valid && core_op == `CPSFR_OP_SLEEP && !dev_reset && !watchdog_timer_expired
    |=> watchdog_timeout_flag_n && !powerdown_flag_n; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_wclr; core_valid && core_op == `CPSFR_OP_WDTCLR && !dev_reset && !watchdog_timer_expired
    |=> watchdog_timeout_flag_n && powerdown_flag_n; endproperty
  a_wclr: assert property (p_wclr) else $error("watchdog clear flags wrong");
  property p_wake; dev_reset
    |=> processor_status[7:5] == {$past(wake_pin_cause), $past(wake_cmp_cause), 1'b0}; endproperty
  a_wake: assert property (p_wake) else $error("wake cause flags wrong");
  property p_page; 1'b1 |=> jump_target == {$past(processor_status[5]), $past(jump_offset)}; endproperty
  a_page: assert property (p_page) else $error("jump target page wrong");
  property p_rd; reg_rd && st && quiet |=> reg_rdata == $past(processor_status); endproperty
  a_rd: assert property (p_rd) else $error("status read data wrong");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside its cycle");
  property p_zero; core_valid && core_op == `CPSFR_OP_ADD && !core_dest_status && !dev_reset
    |=> processor_status[2] == (core_result == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero flag disagrees with result");
endmodule
`default_nettype wire

/* cpsfr_core_model.sv */
// Behavioural model of the core that issues operations to the status block.
// Assumes the bench calls issue from a single process.
`timescale 1ns/1ps
`default_nettype none
`include "cpsfr_defines.vh"
module cpsfr_core_model (
  input  wire logic       sys_clk,
  output var  logic       core_valid,
  output var  logic [3:0] core_op,
  output var  logic       core_dest_status,
  output var  logic [7:0] core_operand_w,
  output var  logic [7:0] core_operand_f,
  output var  logic [2:0] core_bit_sel
);
  initial begin
    {core_valid, core_op, core_dest_status, core_operand_w, core_operand_f, core_bit_sel} = '0;
  end
  task automatic issue(input logic [3:0] o, input logic d, input logic [7:0] w, input logic [7:0] f,
                       input logic [2:0] b);
    @(posedge sys_clk);
    core_valid       <= 1'b1;
    core_op          <= o;
    core_dest_status <= d;
    core_operand_w   <= w;
    core_operand_f   <= f;
    core_bit_sel     <= b;
    @(posedge sys_clk);
    core_valid     <= 1'b0;
    core_op        <= `CPSFR_OP_NONE;
    // Stale operands are inverted so nothing relies on them after the operation.
    core_operand_w <= ~w;
    core_operand_f <= ~f;
    #1;
  endtask
endmodule
`default_nettype wire

/* cpsfr_status_reg_test.sv */
// Self-checking bench for the processor status register block.
// Assumes the core model and the property checker sit in the same folder.
`timescale 1ns/1ps
`default_nettype none
`include "cpsfr_defines.vh"
module cpsfr_status_reg_test;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       dev_reset = 1'b0;
  logic       wake_pin_cause = 1'b0;
  logic       wake_cmp_cause = 1'b0;
  logic       watchdog_timer_expired = 1'b0;
  logic [8:0] jump_offset = 9'h155;
  wire  [7:0] reg_rdata, core_result, processor_status, core_operand_w, core_operand_f;
  wire  [3:0] core_op;
  wire  [2:0] core_bit_sel;
  wire  [9:0] jump_target;
  wire        core_valid, core_dest_status, program_page_select, watchdog_timeout_flag_n, powerdown_flag_n, irq;
  int         mismatches = 0;
  int         check_count = 0;
  // Each entry: op, w, f, expected result, expected zero/digit-carry/carry.
  logic [30:0] alu_tab [9] = '{{4'h5, 8'h08, 8'h08, 8'h10, 3'b010}, {4'h5, 8'h01, 8'hff, 8'h00, 3'b111},
    {4'h6, 8'h01, 8'h10, 8'h0f, 3'b001}, {4'h6, 8'h02, 8'h01, 8'hff, 3'b000}, {4'h6, 8'h05, 8'h05, 8'h00, 3'b111},
    {4'h7, 8'h00, 8'h02, 8'h81, 3'b110}, {4'h8, 8'h00, 8'h81, 8'h02, 3'b111}, {4'h9, 8'h5a, 8'h00, 8'h5a, 3'b011},
    {4'h9, 8'h00, 8'h00, 8'h00, 3'b111}};
  always #2.5 sys_clk = ~sys_clk;
  cpsfr_status_reg dut (.*);
  cpsfr_core_model core (.*);
  ////////////////////////////////////////
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Order of bits: watchdog expiry, device reset, pin cause, comparator cause.
  task automatic ev(input logic [3:0] v);
    @(posedge sys_clk);
    {watchdog_timer_expired, dev_reset, wake_pin_cause, wake_cmp_cause} <= v;
    @(posedge sys_clk);
    {watchdog_timer_expired, dev_reset, wake_pin_cause, wake_cmp_cause} <= 4'h0;
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h03, 8'h18);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h40, 8'hff);
    $display("test reset done");
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h18);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'hff);
    core.issue(`CPSFR_OP_SLEEP, 1'b0, 8'h00, 8'h00, 3'h0);
    rd(8'h03, 8'hf7);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'hf7);
    chk(irq, 1'b0);
    rd(8'h10, 8'h02);
    rd(8'h10, 8'h00);
    wr(8'h11, 8'h07);
    ev(4'b1000);
    chk(irq, 1'b1);
    rd(8'h03, 8'he7);
    rd(8'h10, 8'h01);
    chk(irq, 1'b0);
    core.issue(`CPSFR_OP_WDTCLR, 1'b0, 8'h00, 8'h00, 3'h0);
    rd(8'h03, 8'hff);
    $display("test power flags done");
    wr(8'h03, 8'he2);
    core.issue(`CPSFR_OP_CLEAR_FILE_INSTR, 1'b1, 8'h00, 8'h00, 3'h0);
    chk(processor_status, 8'h1e);
    core.issue(`CPSFR_OP_ADD, 1'b1, 8'hf8, 8'h00, 3'h0);
    chk(processor_status, 8'h1b);
    core.issue(`CPSFR_OP_RRF, 1'b1, 8'h00, 8'h00, 3'h0);
    chk(processor_status, 8'h9b);
    core.issue(`CPSFR_OP_BITSET, 1'b1, 8'h00, 8'h00, 3'h5);
    chk(program_page_select, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(jump_target, 10'h355);
    core.issue(`CPSFR_OP_BITCLR, 1'b1, 8'h00, 8'h00, 3'h5);
    @(posedge sys_clk);
    #1;
    chk(jump_target, 10'h155);
    core.issue(`CPSFR_OP_MOVE, 1'b1, 8'hc0, 8'h00, 3'h0);
    rd(8'h03, 8'hd8);
    ev(4'b0110);
    rd(8'h03, 8'h98);
    ev(4'b0101);
    rd(8'h03, 8'h58);
    ev(4'b0100);
    rd(8'h03, 8'h18);
    rd(8'h10, 8'h04);
    $display("test status writes done");
    for (int i = 0; i < 9; i++) begin
      core.issue(alu_tab[i][30:27], 1'b0, alu_tab[i][26:19], alu_tab[i][18:11], 3'h0);
      chk(core_result, alu_tab[i][10:3]);
      chk(processor_status[2:0], alu_tab[i][2:0]);
    end
    $display("test alu flags done");
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h03, 8'h18);
    $display("test second reset done");
    wrap_up();
  end
endmodule
bind cpsfr_status_reg cpsfr_properties #(.AW(AW)) u_props (.*);
`default_nettype wire
